/* design/universal_serial_module_spi_port.sv */
// SPI personality of the universal serial module, master or slave
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`include "spi_port_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module universal_serial_module_spi_port #(
  parameter int SYNC_STAGES = 3
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire spi_port_pkg::reg_req_t    req_i,
  output var  logic [7:0]                rdata_o,
  input  wire logic                      sub_tick_i,
  input  wire logic                      tmr_tick_i,
  input  wire logic                      sclk_i,
  input  wire logic                      serial_in_i,
  input  wire logic                      slave_select_n_i,
  output var  spi_port_pkg::pin_out_t    pins_o,
  output var  logic [2:0]                pullup_allow_o,
  output var  logic                      irq_o
);

  initial
  begin
    if (SYNC_STAGES != 3)
      $error("SYNC_STAGES must be 3");
  end

  // Registers
  logic [7:0] mode_ctrl_r,  mode_ctrl_nxt;
  logic [7:0] format_r,     format_nxt;
  logic [7:0] data_r,       data_nxt;
  logic [1:0] irq_stat_r,   irq_stat_nxt;
  logic [1:0] irq_mask_r,   irq_mask_nxt;
  logic [7:0] rdata_r,      rdata_nxt;
  spi_port_pkg::xfer_state_t state_r, state_nxt;
  logic [3:0] bit_cnt_r,    bit_cnt_nxt;
  logic [7:0] div_cnt_r,    div_cnt_nxt;
  logic       sclk_r,       sclk_nxt;
  logic       sdo_r,        sdo_nxt;
  logic       rx_bit_r,     rx_bit_nxt;
  logic [2:0] sclk_sy_r,    ssn_sy_r,   sdi_sy_r;

  // Decoded control
  spi_port_pkg::op_mode_t mode;
  logic spi_sel, enabled, is_slave, is_master, idle_lvl, lead_rise, order_msb;
  logic sel_en, busy, slave_active, sclk_rise, sclk_fall, lead_edge, trail_edge;
  logic done_ev, incomplete_ev, write_collision_flag_ev, tick, out_bit, rx_in;

  // Personality from uart bit and mode field
  always_comb
  begin
    mode      = spi_port_pkg::op_mode_t'(mode_ctrl_r[`MC_MODE_HI:`MC_MODE_LO]);
    spi_sel   = !mode_ctrl_r[`MC_UART] && (mode != spi_port_pkg::MODE_I2C)
                && (mode != spi_port_pkg::MODE_UNUSED);
    enabled   = spi_sel && mode_ctrl_r[`MC_ENABLE];
    is_slave  = enabled && (mode == spi_port_pkg::MODE_SLAVE);
    is_master = enabled && !is_slave;
    idle_lvl  = !format_r[`FC_POLARITY];
    // Slave capture edge is rising when edge bit differs from polarity inverse
    lead_rise = format_r[`FC_EDGE] ^ !format_r[`FC_POLARITY];
    order_msb = format_r[`FC_ORDER];
    sel_en    = format_r[`FC_SEL_EN];
    busy      = (state_r != spi_port_pkg::ST_IDLE);
  end

  // Three-stage synchronisers for link pins
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sclk_sy_r <= 3'h7;
      ssn_sy_r  <= 3'h7;
      sdi_sy_r  <= 3'h0;
    end
    else
    begin
      sclk_sy_r <= {sclk_sy_r[1:0], sclk_i};
      ssn_sy_r  <= {ssn_sy_r[1:0], slave_select_n_i};
      sdi_sy_r  <= {sdi_sy_r[1:0], serial_in_i};
    end
  end

  // Edge detect uses only stages two and three
  always_comb
  begin
    sclk_rise    = sclk_sy_r[1] && !sclk_sy_r[2];
    sclk_fall    = !sclk_sy_r[1] && sclk_sy_r[2];
    slave_active = !sel_en || !ssn_sy_r[2];
    case (mode)
      spi_port_pkg::MODE_M_DIV4:  tick = (div_cnt_r >= `DIV4_HALF - 8'd1);
      spi_port_pkg::MODE_M_DIV16: tick = (div_cnt_r >= `DIV16_HALF - 8'd1);
      spi_port_pkg::MODE_M_DIV64: tick = (div_cnt_r >= `DIV64_HALF - 8'd1);
      spi_port_pkg::MODE_M_SUB:   tick = sub_tick_i;
      spi_port_pkg::MODE_M_TMR:   tick = tmr_tick_i;
      default:                    tick = 1'b0;
    endcase
    out_bit = order_msb ? data_r[7] : data_r[0];
    // Master reads the synced pin late, at the trailing edge, past the sync delay
    rx_in   = is_master ? sdi_sy_r[2] : rx_bit_r;
  end

  // Transfer engine next state
  always_comb
  begin
    state_nxt     = state_r;
    bit_cnt_nxt   = bit_cnt_r;
    div_cnt_nxt   = 8'h00;
    sclk_nxt      = idle_lvl;
    sdo_nxt       = sdo_r;
    rx_bit_nxt    = rx_bit_r;
    data_nxt      = data_r;
    done_ev       = 1'b0;
    incomplete_ev = 1'b0;
    lead_edge     = 1'b0;
    trail_edge    = 1'b0;
    write_collision_flag_ev       = 1'b0;
    if (is_master)
    begin
      // Master makes clock from its divider, or from the sub-clock or timer tick
      lead_edge  = busy && tick && (state_r == spi_port_pkg::ST_LEAD);
      trail_edge = busy && tick && (state_r == spi_port_pkg::ST_TRAIL);
      div_cnt_nxt = (busy && !tick) ? div_cnt_r + 8'd1 : 8'h00;
      sclk_nxt = sclk_r;
      if (!busy)
        sclk_nxt = idle_lvl;
      else if (tick)
        sclk_nxt = !sclk_r;
    end
    else if (is_slave && slave_active)
    begin
      // Slave shifts only on peer clock
      lead_edge  = busy && (lead_rise ? sclk_rise : sclk_fall);
      trail_edge = busy && (lead_rise ? sclk_fall : sclk_rise);
    end
    if (!enabled)
      state_nxt = spi_port_pkg::ST_IDLE;
    else if (is_slave && sel_en && ssn_sy_r[2] && busy)
    begin
      // Select lifted mid-byte
      state_nxt     = spi_port_pkg::ST_IDLE;
      incomplete_ev = 1'b1;
      done_ev       = 1'b1;
    end
    else if (lead_edge)
    begin
      rx_bit_nxt = sdi_sy_r[2];
      state_nxt  = spi_port_pkg::ST_TRAIL;
    end
    else if (trail_edge)
    begin
      // Shift in captured bit, present next out
      data_nxt    = order_msb ? {data_r[6:0], rx_in} : {rx_in, data_r[7:1]};
      sdo_nxt     = order_msb ? data_r[6] : data_r[1];
      bit_cnt_nxt = bit_cnt_r + 4'd1;
      state_nxt   = spi_port_pkg::ST_LEAD;
      if (bit_cnt_r == `BITS_PER_BYTE - 4'd1)
      begin
        state_nxt = spi_port_pkg::ST_IDLE;
        done_ev   = 1'b1;
      end
    end
    // Data write starts a transfer
    if (req_i.wr && req_i.addr == `ADDR_DATA_BUF && spi_sel)
    begin
      if (busy)
        write_collision_flag_ev = 1'b1;
      else
      begin
        data_nxt    = req_i.wdata;
        sdo_nxt     = order_msb ? req_i.wdata[7] : req_i.wdata[0];
        bit_cnt_nxt = 4'd0;
        if (enabled)
          state_nxt = spi_port_pkg::ST_LEAD;
      end
    end
  end

  // Register file next values and read mux
  always_comb
  begin
    mode_ctrl_nxt = mode_ctrl_r;
    format_nxt    = format_r;
    irq_stat_nxt  = irq_stat_r;
    irq_mask_nxt  = irq_mask_r;
    rdata_nxt     = 8'h00;
    if (req_i.wr)
    begin
      case (req_i.addr)
        `ADDR_MODE_CTRL:   mode_ctrl_nxt = req_i.wdata;
        `ADDR_FORMAT_CTRL: if (spi_sel) format_nxt = req_i.wdata;
        `ADDR_IRQ_STATUS:  irq_stat_nxt = irq_stat_r & ~req_i.wdata[1:0];
        `ADDR_IRQ_MASK:    irq_mask_nxt = req_i.wdata[1:0];
        default:           ;
      endcase
    end
    // Hardware sets win over software clears
    if (done_ev)
    begin
      format_nxt[`FC_DONE] = 1'b1;
      irq_stat_nxt[0]      = 1'b1;
    end
    if (write_collision_flag_ev)
    begin
      format_nxt[`FC_WRITE_COLLISION_FLAG] = 1'b1;
      irq_stat_nxt[1]      = 1'b1;
    end
    if (incomplete_ev)
      mode_ctrl_nxt[`MC_INCOMPLETE] = 1'b1;
    if (req_i.rd)
    begin
      case (req_i.addr)
        `ADDR_MODE_CTRL:   rdata_nxt = mode_ctrl_r;
        `ADDR_FORMAT_CTRL: rdata_nxt = spi_sel ? format_r : 8'h00;
        `ADDR_DATA_BUF:    rdata_nxt = spi_sel ? data_r : 8'h00;
        `ADDR_IRQ_STATUS:  rdata_nxt = {6'h00, irq_stat_r};
        `ADDR_IRQ_MASK:    rdata_nxt = {6'h00, irq_mask_r};
        default:           rdata_nxt = 8'h00;
      endcase
    end
  end

  // State registers
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mode_ctrl_r <= `MODE_CTRL_RESET;
      format_r    <= `FORMAT_RESET;
      data_r      <= 8'h00;
      irq_stat_r  <= 2'h0;
      irq_mask_r  <= 2'h0;
      rdata_r     <= 8'h00;
      state_r     <= spi_port_pkg::ST_IDLE;
      bit_cnt_r   <= 4'h0;
      div_cnt_r   <= 8'h00;
      sclk_r      <= 1'b1;
      sdo_r       <= 1'b0;
      rx_bit_r    <= 1'b0;
    end
    else
    begin
      mode_ctrl_r <= mode_ctrl_nxt;
      format_r    <= format_nxt;
      data_r      <= data_nxt;
      irq_stat_r  <= irq_stat_nxt;
      irq_mask_r  <= irq_mask_nxt;
      rdata_r     <= rdata_nxt;
      state_r     <= state_nxt;
      bit_cnt_r   <= bit_cnt_nxt;
      div_cnt_r   <= div_cnt_nxt;
      sclk_r      <= sclk_nxt;
      sdo_r       <= sdo_nxt;
      rx_bit_r    <= rx_bit_nxt;
    end
  end

  // Pin drive from mode and enables
  always_comb
  begin
    pins_o.sclk_o  = sclk_r;
    pins_o.sclk_oe = is_master;
    pins_o.sdo_o   = sdo_r;
    pins_o.sdo_oe  = is_master || (is_slave && slave_active);
    pins_o.ssn_o   = !busy;
    pins_o.ssn_oe  = is_master && sel_en;
    // Pull-ups: select, sclk, serial_in when inputs
    pullup_allow_o = {is_slave && sel_en, is_slave, enabled};
    rdata_o        = rdata_r;
    irq_o          = |(irq_stat_r & irq_mask_r);
  end

endmodule : universal_serial_module_spi_port
`default_nettype wire

/* design/spi_port_consts.svh */
// Offsets, field positions, reset values and timing counts of the serial port
// Behaviour
// - Master starts every full-duplex transfer
// - Master makes clock; slave shifts with it
// - Exactly one active-low slave select line
// - Select enable set: select works, else float
// - Personality from uart bit and mode field
// - One data register for transmit and receive
// - Received byte readable in data register
// - Format and data registers only in SPI
// - Software picks LSB or MSB first
// - Software picks rising or falling capture edge; master ignores the edge bit
// - Pin states follow mode and enable bits
// - Pull-ups only when enabled and pin input
// - Mode codes pick master divider or slave
// - Polarity zero idles high, one idles low
// - Done flag set by hardware, software clears
// - Write during transfer ignored, collision flag set
`ifndef SPI_PORT_CONSTS_SVH
`define SPI_PORT_CONSTS_SVH

`define ADDR_MODE_CTRL    3'h0
`define ADDR_FORMAT_CTRL  3'h1
`define ADDR_DATA_BUF     3'h2
`define ADDR_IRQ_STATUS   3'h3
`define ADDR_IRQ_MASK     3'h4

`define MODE_CTRL_RESET   8'he0
`define FORMAT_RESET      8'h00

`define MC_MODE_HI        7
`define MC_MODE_LO        5
`define MC_UART           4
`define MC_ENABLE         1
`define MC_INCOMPLETE     0

`define FC_POLARITY       5
`define FC_EDGE           4
`define FC_ORDER          3
`define FC_SEL_EN         2
`define FC_WRITE_COLLISION_FLAG           1
`define FC_DONE           0

`define DIV4_HALF         8'd2
`define DIV16_HALF        8'd8
`define DIV64_HALF        8'd32
`define BITS_PER_BYTE     4'd8

`endif

/* design/spi_port_pkg.sv */
// Types shared by the serial port
package spi_port_pkg;

  typedef enum logic [2:0] {
    MODE_M_DIV4  = 3'b000,
    MODE_M_DIV16 = 3'b001,
    MODE_M_DIV64 = 3'b010,
    MODE_M_SUB   = 3'b011,
    MODE_M_TMR   = 3'b100,
    MODE_SLAVE   = 3'b101,
    MODE_I2C     = 3'b110,
    MODE_UNUSED  = 3'b111
  } op_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LEAD  = 2'b01,
    ST_TRAIL = 2'b10
  } xfer_state_t;

  // Register bus request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  // Pin bundle toward the link
  typedef struct packed {
    logic sclk_o;
    logic sclk_oe;
    logic sdo_o;
    logic sdo_oe;
    logic ssn_o;
    logic ssn_oe;
  } pin_out_t;

endpackage : spi_port_pkg

/* verif/spi_peer_model.sv */
// Behavioural SPI peer that answers the port's master transfers
`timescale 1ns/10ps
`default_nettype none
module spi_peer_model (
  input  wire logic       sclk_i,
  input  wire logic       ssn_n_i,
  input  wire logic       ssn_oe_i,
  input  wire logic       sdo_i,
  input  wire logic       msb_i,
  input  wire logic [7:0] tx_i,
  output var  logic       miso_o,
  output var  logic [7:0] rx_o
);
  logic       idle_r = 1'b1;
  logic [2:0] idx_r = 3'h0;
  initial miso_o = 1'b0;
  initial rx_o = 8'h00;
  // Frame opened by the master: note idle level, show first bit
  always @(negedge ssn_n_i)
  begin
    idle_r = sclk_i;
    idx_r = 3'h0;
    #1 miso_o = msb_i ? tx_i[7] : tx_i[0];
  end
  // Capture on the leading edge, next bit after the trailing edge
  always @(sclk_i)
  begin
    if (ssn_oe_i && !ssn_n_i)
    begin
      if (sclk_i != idle_r)
        rx_o = {rx_o[6:0], sdo_i};
      else
      begin
        idx_r = idx_r + 3'h1;
        #1 miso_o = msb_i ? tx_i[3'h7 - idx_r] : tx_i[idx_r];
      end
    end
  end
  // Released line shows the inverse of its last bit
  always @(posedge ssn_n_i)
    #1 miso_o = ~miso_o;
endmodule : spi_peer_model
`default_nettype wire

/* verif/universal_serial_module_spi_port_assertions.sv */
// Checker of the SPI port's bus answers and master pins
`include "spi_port_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module universal_serial_module_spi_port_assertions #(
  parameter int SYNC_STAGES = 3
) (
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  input wire spi_port_pkg::reg_req_t req_i,
  input wire logic [7:0]             rdata_o,
  input wire spi_port_pkg::pin_out_t pins_o,
  input wire logic [2:0]             pullup_allow_o,
  input wire logic                   irq_o
);
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic       sclk_r;
  logic       chg;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Clock edges seen since the select fell
  always_comb
  begin
    chg = pins_o.sclk_o != sclk_r;
    cnt_nxt = pins_o.ssn_o ? 5'h00 : cnt_r + 5'(chg);
  end
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      {cnt_r, sclk_r} <= 6'h01;
    else
      {cnt_r, sclk_r} <= {cnt_nxt, pins_o.sclk_o};
  end
  sequence s_mode_wr;
    req_i.wr && req_i.addr == `ADDR_MODE_CTRL;
  endsequence
  sequence s_mode_rd;
    req_i.rd && req_i.addr == `ADDR_MODE_CTRL;
  endsequence
  property p_mode_rd;
    s_mode_wr ##1 !req_i.wr ##1 s_mode_rd |=> rdata_o == $past(req_i.wdata, 3);
  endproperty
  a_mode_rd: assert property (p_mode_rd) else $error("mode readback wrong");
  property p_rd_idle;
    !req_i.rd |=> rdata_o == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer");
  property p_unmapped;
    req_i.rd && req_i.addr > `ADDR_IRQ_MASK |=> rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_sclk_half;
    $changed(pins_o.sclk_o) && !pins_o.ssn_o |=> $stable(pins_o.sclk_o);
  endproperty
  a_sclk_half: assert property (p_sclk_half) else $error("clock half period short");
  property p_sclk_idle;
    $changed(pins_o.sclk_o) && pins_o.ssn_o && $past(pins_o.ssn_o)
      |-> $past(req_i.wr, 2) && $past(req_i.addr, 2) == `ADDR_FORMAT_CTRL;
  endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("clock moved outside frame");
  property p_frame;
    $rose(pins_o.ssn_o) && $past(pins_o.ssn_oe) |-> cnt_r + 5'(chg) == 5'd16;
  endproperty
  a_frame: assert property (p_frame) else $error("frame edge count wrong");
  property p_irq_fall;
    $fell(irq_o) |-> $past(req_i.wr);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt fell unasked");
  property p_pullup;
    pins_o.sclk_oe |-> !pullup_allow_o[1];
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up on driven clock");
endmodule : universal_serial_module_spi_port_assertions
bind universal_serial_module_spi_port universal_serial_module_spi_port_assertions #(.SYNC_STAGES(SYNC_STAGES)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .rdata_o(rdata_o), .pins_o(pins_o),
  .pullup_allow_o(pullup_allow_o), .irq_o(irq_o));
`default_nettype wire

/* verif/universal_serial_module_spi_port_tb.sv */
// Bench of the SPI port: register access, master transfers, flags
`include "spi_port_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module universal_serial_module_spi_port_tb;
  logic                   clk_i = 1'b0;
  logic                   rst_i = 1'b1;
  logic                   tick = 1'b0;
  logic [1:0]             tcnt = 2'h0;
  logic                   msb = 1'b1;
  logic [7:0]             peer_tx = 8'h00;
  logic [7:0]             got;
  spi_port_pkg::reg_req_t req = '0;
  spi_port_pkg::pin_out_t pins;
  logic [7:0]             rdata;
  logic [7:0]             peer_rx;
  logic [2:0]             pull;
  logic                   irq;
  logic                   miso;
  int                     fail_count = 0;
  int                     cmp_count = 0;
  always #2 clk_i = ~clk_i;
  // Sub-clock and timer ticks every fourth cycle
  always @(posedge clk_i)
  begin
    tcnt <= tcnt + 2'h1;
    tick <= tcnt == 2'h3;
  end
  universal_serial_module_spi_port u_universal_serial_module_spi_port (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .rdata_o(rdata),
    .sub_tick_i(tick), .tmr_tick_i(tick), .sclk_i(1'b1), .serial_in_i(miso),
    .slave_select_n_i(1'b1), .pins_o(pins), .pullup_allow_o(pull), .irq_o(irq));
  spi_peer_model u_spi_peer_model (.sclk_i(pins.sclk_o), .ssn_n_i(pins.ssn_o),
    .ssn_oe_i(pins.ssn_oe), .sdo_i(pins.sdo_o), .msb_i(msb), .tx_i(peer_tx),
    .miso_o(miso), .rx_o(peer_rx));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One strobe cycle, then an idle cycle holding the answer
  task automatic bus(input logic [2:0] a, input logic [7:0] d, input logic w);
    req <= '{a, d, w, !w};
    @(posedge clk_i);
    req <= '0;
    #1 got = rdata;
    @(posedge clk_i);
  endtask : bus
  task automatic xfer(input logic [2:0] m, input logic [7:0] f, input logic [7:0] d,
                      input logic k);
    int         c;
    logic [7:0] e;
    c = 0;
    e = {<<{d}};
    bus(`ADDR_MODE_CTRL, {m, 5'h02}, 1'b1);
    bus(`ADDR_FORMAT_CTRL, f, 1'b1);
    #1;
    check("idle clock", 8'(pins.sclk_o), 8'(!f[5]));
    check("select driven", 8'(pins.ssn_oe), 8'h01);
    @(posedge clk_i);
    msb = f[3];
    peer_tx = ~d;
    if (msb)
      e = d;
    bus(`ADDR_DATA_BUF, d, 1'b1);
    if (k)
      bus(`ADDR_DATA_BUF, 8'hff, 1'b1);
    while (pins.ssn_o !== 1'b1 && c < 3000)
    begin
      @(posedge clk_i);
      c++;
    end
    check("wait", 8'(c < 3000), 8'h01);
    check("done irq", 8'(irq), 8'h01);
    if (m < 3'h3)
      check("cycles", 8'(c > (32 << (2 * m)) - 9 && c < (32 << (2 * m)) + 9), 8'h01);
    bus(`ADDR_IRQ_STATUS, 8'h00, 1'b0);
    check("status", got, {6'h00, k, 1'b1});
    bus(`ADDR_DATA_BUF, 8'h00, 1'b0);
    check("rx byte", got, ~d);
    check("tx byte", peer_rx, e);
    bus(`ADDR_IRQ_MASK, 8'h00, 1'b1);
    check("masked", 8'(irq), 8'h00);
    bus(`ADDR_IRQ_MASK, 8'h03, 1'b1);
    bus(`ADDR_IRQ_STATUS, 8'h03, 1'b1);
    check("cleared", 8'(irq), 8'h00);
  endtask : xfer
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test
  // Reset, register checks, then one transfer per master mode
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check("pull-ups", 8'(pull), 8'h00);
    bus(`ADDR_MODE_CTRL, 8'h00, 1'b0);
    check("mode reset", got, 8'he0);
    bus(`ADDR_FORMAT_CTRL, 8'h3c, 1'b1);
    bus(3'h7, 8'h00, 1'b0);
    check("unmapped", got, 8'h00);
    bus(`ADDR_MODE_CTRL, 8'h02, 1'b1);
    bus(`ADDR_MODE_CTRL, 8'h00, 1'b0);
    check("mode", got, 8'h02);
    bus(`ADDR_FORMAT_CTRL, 8'h00, 1'b0);
    check("format", got, 8'h00);
    bus(`ADDR_IRQ_MASK, 8'h03, 1'b1);
    for (int i = 0; i < 5; i++)
      xfer(3'(i), {2'h0, i[0], i[1], !i[0], 3'h4}, 8'ha5 ^ 8'(i * 17), 1'(i == 2));
    bus(`ADDR_FORMAT_CTRL, 8'h00, 1'b1);
    check("select float", 8'(pins.ssn_oe), 8'h00);
    stop_test();
  end
endmodule : universal_serial_module_spi_port_tb
`default_nettype wire
